//--- core/supervisor_cfg.svh
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the package and design files
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

`define FRAME_BITS           24
`define ADDR_MSB             23
`define ADDR_LSB             22
`define ADDR_CR0             2'h0
`define ADDR_CR1             2'h1
`define ADDR_CR2             2'h2
`define CLEAR_CMD_BIT        21
`define CFG_RESET            22'h000000
`define STATUS_RESET         22'h000000
`define BIT_POWER_ON         19
`define BIT_LIN_WAKE         18
`define BIT_INHIBIT_WAKE     17
`define BIT_SECOND_REG_SHORT 12
`define CLK_MHZ              50
`define SHORT_TIME_US        4000
`define SHORT_CYCLES         (`SHORT_TIME_US * `CLK_MHZ)
`define STATIC_FILTER_US     64
`define STATIC_FILTER_CYC    (`STATIC_FILTER_US * `CLK_MHZ)
`define CYCLIC_FILTER_US     16
`define CYCLIC_FILTER_CYC    (`CYCLIC_FILTER_US * `CLK_MHZ)
`define SHORT_DELAY_US       80
`define SHORT_DELAY_CYC      (`SHORT_DELAY_US * `CLK_MHZ)
`define LONG_DELAY_US        800
`define LONG_DELAY_CYC       (`LONG_DELAY_US * `CLK_MHZ)

`endif

//--- core/supervisor_pkg.sv
// Types shared by the supervisor register bank
// Assumes supervisor_cfg.svh on the include path
`include "supervisor_cfg.svh"
package supervisor_pkg;
  typedef enum logic [1:0] {
    filt_static     = 2'b00,
    filt_short_tmr2 = 2'b01,
    filt_long_tmr2  = 2'b10,
    filt_long_tmr1  = 2'b11
  } filter_mode_t;

  typedef enum logic [1:0] {
    wf_idle   = 2'b00,
    wf_delay  = 2'b01,
    wf_filter = 2'b10
  } wake_state_t;

  typedef struct packed {
    logic [1:0]  sync;
    logic        stable;
    wake_state_t state;
    logic [17:0] cnt;
  } wake_filter_t;
endpackage

//--- core/wake_input_filter.sv
// One wake input filter: static or cyclic sense window
// Assumes raw pin input and timer phase strobes from outside
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module wake_input_filter (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Configuration and timing
  input  wire logic [1:0] mode_i,
  input  wire logic       timer1_phase_i,
  input  wire logic       timer2_phase_i,
  // Pin and result
  input  wire logic       pin_i,
  output logic            level_o
);
  supervisor_pkg::wake_filter_t st;
  supervisor_pkg::wake_filter_t next_st;
  logic        phase;
  logic [17:0] delay_cyc;
  logic [17:0] filt_cyc;

  always_comb begin
    next_st = st;
    next_st.sync = {st.sync[0], pin_i};
    phase = (mode_i == 2'b11) ? timer1_phase_i : timer2_phase_i;
    delay_cyc = (mode_i == 2'b01) ? 18'(`SHORT_DELAY_CYC)
                                  : 18'(`LONG_DELAY_CYC);
    filt_cyc = (mode_i == 2'b00) ? 18'(`STATIC_FILTER_CYC)
                                 : 18'(`CYCLIC_FILTER_CYC);
    case (st.state)
      supervisor_pkg::wf_idle: begin
        next_st.cnt = 18'h00000;
        if (mode_i == 2'b00) begin
          next_st.state = supervisor_pkg::wf_filter;
        end else if (phase) begin
          next_st.state = supervisor_pkg::wf_delay;
        end
      end
      supervisor_pkg::wf_delay: begin
        if (!phase) begin
          next_st.state = supervisor_pkg::wf_idle;
        end else if (st.cnt >= delay_cyc - 18'h00001) begin
          next_st.cnt = 18'h00000;
          next_st.state = supervisor_pkg::wf_filter;
        end else begin
          next_st.cnt = st.cnt + 18'h00001;
        end
      end
      supervisor_pkg::wf_filter: begin
        if (mode_i != 2'b00 && !phase) begin
          next_st.state = supervisor_pkg::wf_idle;
        end else if (st.sync[1] == st.stable) begin
          next_st.cnt = 18'h00000;
        end else if (st.cnt >= filt_cyc - 18'h00001) begin
          next_st.cnt = 18'h00000;
          next_st.stable = st.sync[1];
        end else begin
          next_st.cnt = st.cnt + 18'h00001;
        end
      end
      default: begin
        next_st.state = supervisor_pkg::wf_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.stable;
endmodule

//--- core/supervisor_regs.sv
// Third control register and first status register behind the SPI link
// Assumes an SPI master, mode 0, MSB first, 24-bit frames, and analog
// fault detectors presenting levels from outside the clock domain
`timescale 1ns/1ps
`include "supervisor_cfg.svh"

// Function
// - Threshold bits pick 2mA or 8mA
// - Lockout off: outputs recover after supply fault
// - Lockout on: outputs off until clear
// - Recovery bit sets strong driver recovery
// - Pull-up disable bit removes bus pull-up
// - Timeout disable bit drops dominant timeout
// - Reset level 00 4.65V, 01 4.35V
// - Filter 00 is static 64us
// - Filter 01 cyclic, timer2, 80us delay
// - Filter 10/11 cyclic 800us, timer2/timer1
// - Slope bit 0 high, 1 low
// - Relay fault shutdown unless bit set
// - Standby current supervision enabled at zero
// - Status shifted out on every access
// - Over-current flags latch detections
// - Open-load flags latch detections
// - Second regulator short after 4ms below 2V
// - Wake state bits show filtered inputs
// - Wake source flags show initiator
// - Power-on flag cleared by first access
// - Clear command empties status apart from wake state bits and events arriving in the same cycle
module supervisor_regs (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // SPI link
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_clk_i,
  input  wire logic       spi_di_i,
  output logic            spi_do_o,
  // Fault and wake sources
  input  wire logic [3:0] small_driver_overcurrent_i,
  input  wire logic       strong_driver_overcurrent_i,
  input  wire logic [1:0] relay_overcurrent_i,
  input  wire logic [3:0] small_driver_open_load_i,
  input  wire logic       strong_driver_open_load_i,
  input  wire logic       second_reg_low_i,
  input  wire logic       second_reg_turn_on_i,
  input  wire logic [3:0] wake_pin_i,
  input  wire logic       inhibit_wake_i,
  input  wire logic       lin_wake_i,
  input  wire logic       supply_fault_i,
  input  wire logic       timer1_phase_i,
  input  wire logic       timer2_phase_i,
  // Analog controls
  output logic [3:0]      open_load_threshold_sel_o,
  output logic            outputs_enable_o,
  output logic            relay_low_side_outputs_en_o,
  output logic            strong_driver_recovery_en_o,
  output logic            bus_pullup_disable_o,
  output logic            dominant_timeout_disable_o,
  output logic [1:0]      reset_level_o,
  output logic            bus_low_slew_o,
  output logic            standby_current_supervision_o
);
  typedef struct packed {
    logic [1:0]  cs_s;
    logic [1:0]  clk_s;
    logic [1:0]  di_s;
    logic        clk_d;
    logic [4:0]  bitcnt;
    logic [23:0] shin;
    logic [21:0] shout;
    logic        dout;
    logic [21:0] cfg;
    logic [21:0] status;
    logic [21:0] src_a;
    logic [21:0] src_b;
    logic        lockout;
    logic [17:0] short_cnt;
    logic        first_access;
    logic [1:0]  fault_s;
    logic [1:0]  reg_low_s;
    logic [1:0]  reg_on_s;
  } regs_t;

  regs_t       r;
  regs_t       next_r;
  logic [3:0]  wake_level;
  logic [21:0] events;
  logic        cs_active;
  logic        rise;
  logic        fall;
  logic        frame_end;
  logic [1:0]  addr;
  logic        clear_cmd;

  ////////////////////////////////////////////////////////////////////////
  // Wake input filters
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : wake
      wake_input_filter filt (
        .clk_i          (clk_i),
        .reset_n_i      (reset_n_i),
        .mode_i         (r.cfg[9 + 2*g +: 2]),
        .timer1_phase_i (timer1_phase_i),
        .timer2_phase_i (timer2_phase_i),
        .pin_i          (wake_pin_i[g]),
        .level_o        (wake_level[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_r = r;
    next_r.cs_s  = {r.cs_s[0], spi_cs_n_i};
    next_r.clk_s = {r.clk_s[0], spi_clk_i};
    next_r.di_s  = {r.di_s[0], spi_di_i};
    next_r.fault_s   = {r.fault_s[0], supply_fault_i};
    next_r.reg_low_s = {r.reg_low_s[0], second_reg_low_i};
    next_r.reg_on_s  = {r.reg_on_s[0], second_reg_turn_on_i};
    next_r.src_a = {2'b00, 1'b0, lin_wake_i, inhibit_wake_i, 4'h0, 1'b0,
                    relay_overcurrent_i, strong_driver_overcurrent_i,
                    small_driver_overcurrent_i, strong_driver_open_load_i,
                    small_driver_open_load_i};
    next_r.src_b = r.src_a;
    next_r.clk_d = r.clk_s[1];
    cs_active = !r.cs_s[1];
    rise = cs_active && r.clk_s[1] && !r.clk_d;
    fall = cs_active && !r.clk_s[1] && r.clk_d;
    frame_end = r.cs_s[1] && r.bitcnt == 5'd24;
    addr = r.shin[`ADDR_MSB:`ADDR_LSB];
    clear_cmd = frame_end && addr == `ADDR_CR1 && r.shin[`CLEAR_CMD_BIT];
    // Sticky fault flags; a new event wins over a clear
    events = r.src_b;
    if (r.reg_on_s[1] && r.reg_low_s[1]) begin
      if (r.short_cnt >= 18'(`SHORT_CYCLES)) begin
        events[`BIT_SECOND_REG_SHORT] = 1'b1;
      end else begin
        next_r.short_cnt = r.short_cnt + 18'h00001;
      end
    end else begin
      next_r.short_cnt = 18'h00000;
    end
    if (clear_cmd) begin
      next_r.status = 22'h000000;
      next_r.lockout = 1'b0;
    end else if (frame_end && r.first_access) begin
      next_r.status[`BIT_POWER_ON] = 1'b0;
    end
    if (frame_end) begin
      next_r.first_access = 1'b0;
    end
    next_r.status = next_r.status | events;
    next_r.status[16:13] = wake_level;
    next_r.status[21:20] = 2'b00;
    if (r.fault_s[1] && r.cfg[4]) begin
      next_r.lockout = 1'b1;
    end
    // SPI shift
    if (r.cs_s[1]) begin
      next_r.bitcnt = 5'd0;
      next_r.dout = 1'b0;
    end else if (rise && r.bitcnt < 5'd24) begin
      next_r.shin = {r.shin[22:0], r.di_s[1]};
      next_r.bitcnt = r.bitcnt + 5'd1;
      if (r.bitcnt == 5'd1) begin
        next_r.shout = r.status;
      end
    end else if (fall && r.bitcnt >= 5'd2 && r.bitcnt < 5'd24) begin
      next_r.dout = r.shout[21];
      next_r.shout = {r.shout[20:0], 1'b0};
    end
    if (frame_end) begin
      next_r.bitcnt = 5'd0;
      if (addr == `ADDR_CR2) begin
        next_r.cfg = r.shin[21:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
      r.cs_s <= 2'b11;
      r.cfg <= `CFG_RESET;
      r.status <= 22'h080000;
      r.first_access <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spi_do_o <= 1'b0;
      open_load_threshold_sel_o <= 4'h0;
      outputs_enable_o <= 1'b0;
      relay_low_side_outputs_en_o <= 1'b0;
      strong_driver_recovery_en_o <= 1'b0;
      bus_pullup_disable_o <= 1'b0;
      dominant_timeout_disable_o <= 1'b0;
      reset_level_o <= 2'b00;
      bus_low_slew_o <= 1'b0;
      standby_current_supervision_o <= 1'b1;
    end else begin
      spi_do_o <= r.dout & cs_active;
      open_load_threshold_sel_o <= r.cfg[3:0];
      outputs_enable_o <= !r.fault_s[1] && !r.lockout;
      relay_low_side_outputs_en_o <= r.cfg[19] ||
                                     !(r.fault_s[1] || r.lockout);
      strong_driver_recovery_en_o <= r.cfg[5];
      bus_pullup_disable_o <= r.cfg[6];
      dominant_timeout_disable_o <= r.cfg[7];
      reset_level_o <= {1'b0, r.cfg[8]};
      bus_low_slew_o <= r.cfg[18];
      standby_current_supervision_o <= !r.cfg[20];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_reserved_zero: assert property (@(posedge clk_i) disable iff
    (!reset_n_i) r.status[21:20] == 2'b00)
    else $error("reserved status bits set");
  a_clear_empties: assert property (@(posedge clk_i) disable iff
    (!reset_n_i) clear_cmd && events == 22'h0 |=>
    r.status[12:0] == 13'h0)
    else $error("clear left flags");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff
    (!reset_n_i) r.src_b[0] |=> r.status[0])
    else $error("open load flag missed");
  a_oc_sticky: assert property (@(posedge clk_i) disable iff
    (!reset_n_i) r.src_b[5] |=> r.status[5])
    else $error("over-current flag missed");
  a_pullup_follow: assert property (@(posedge clk_i) disable iff
    (!reset_n_i) ##1 bus_pullup_disable_o == $past(r.cfg[6]))
    else $error("pull-up control wrong");
  a_lockout_hold: assert property (@(posedge clk_i) disable iff
    (!reset_n_i) r.lockout && !clear_cmd |=> !outputs_enable_o)
    else $error("outputs on during lockout");
  a_level_safe: assert property (@(posedge clk_i) disable iff
    (!reset_n_i) !reset_level_o[1])
    else $error("reserved reset level driven");
  a_supervise_on: assert property (@(posedge clk_i) disable iff
    (!reset_n_i) !r.cfg[20] |=> standby_current_supervision_o)
    else $error("supervision disabled");
endmodule

//--- verif/spi_host_model.sv
// Behavioural SPI host: mode 0, MSB first, 24-bit frames
// Assumes the device samples its pins with its own clock
`timescale 1ns/1ps
module spi_host_model #(
  parameter int HALF_NS = 80
) (
  // SPI link
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One whole frame; clock stands low outside it
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    // Move edges off the device clock edge
    #5;
    cs_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi_o = tx[i];
      #(HALF_NS);
      sclk_o = 1'b1;
      rx[i] = miso_i;
      #(HALF_NS);
      sclk_o = 1'b0;
    end
    #(HALF_NS);
    cs_n_o = 1'b1;
    mosi_o = ~tx[0];
  endtask
endmodule

//--- verif/test_supervisor_config_and_fault_status.sv
// Bench for the supervisor register bank
// Assumes spi_host_model and supervisor_regs are compiled first
`timescale 1ns/1ps
module test_supervisor_config_and_fault_status;
  typedef struct packed {
    logic [21:0] cfg;
    logic [10:0] outs;
    logic [21:0] st;
  } row_t;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cs_n, sclk, di, dout;
  logic [11:0] flt = 12'h000;
  logic [3:0]  wake = 4'h0;
  logic        external_inhibit_wake_flag = 1'b0;
  logic        lin = 1'b0;
  logic        sfault = 1'b0;
  logic        tmr2 = 1'b0;
  logic [3:0]  thr;
  logic [1:0]  lvl;
  logic        oen, rel, rec, pu, tmo, slew, sup;
  logic [10:0] outs;
  logic [23:0] rx;
  int          fail_count = 0;
  int          checked = 0;
  // Rows keep the upper reset level bit at zero
  row_t rows [3] = '{
    '{22'h000000, 11'h001, 22'h080000},
    '{22'h1401e5, 11'h2f6, 22'h000000},
    '{22'h00014a, 11'h525, 22'h000000}};

  assign outs = {thr, rec, pu, tmo, lvl, slew, sup};
  always #10 clk_i = ~clk_i;

  spi_host_model i_host (.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(di),
    .miso_i(dout));

  supervisor_regs i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .spi_cs_n_i(cs_n), .spi_clk_i(sclk), .spi_di_i(di), .spi_do_o(dout),
    .small_driver_overcurrent_i(flt[8:5]),
    .strong_driver_overcurrent_i(flt[9]),
    .relay_overcurrent_i(flt[11:10]),
    .small_driver_open_load_i(flt[3:0]),
    .strong_driver_open_load_i(flt[4]),
    .second_reg_low_i(1'b0), .second_reg_turn_on_i(1'b0),
    .wake_pin_i(wake), .inhibit_wake_i(external_inhibit_wake_flag), .lin_wake_i(lin),
    .supply_fault_i(sfault), .timer1_phase_i(1'b0), .timer2_phase_i(tmr2),
    .open_load_threshold_sel_o(thr), .outputs_enable_o(oen),
    .relay_low_side_outputs_en_o(rel), .strong_driver_recovery_en_o(rec),
    .bus_pullup_disable_o(pu), .dominant_timeout_disable_o(tmo),
    .reset_level_o(lvl), .bus_low_slew_o(slew),
    .standby_current_supervision_o(sup));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic frame(input logic [23:0] tx);
    i_host.xfer(tx, rx);
    repeat (5) @(posedge clk_i);
  endtask

  task automatic supply(input logic v);
    @(posedge clk_i);
    sfault <= v;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic results;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    results;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    foreach (rows[k]) begin
      frame({2'h2, rows[k].cfg});
      check(rx, {2'h0, rows[k].st});
      check({13'h0, outs}, {13'h0, rows[k].outs});
      $display("row %0d done", k);
    end
    // Latched faults and wake sources, then clear
    @(posedge clk_i);
    flt <= 12'ha5c;
    external_inhibit_wake_flag <= 1'b1;
    lin <= 1'b1;
    repeat (5) @(posedge clk_i);
    flt <= 12'h000;
    external_inhibit_wake_flag <= 1'b0;
    lin <= 1'b0;
    repeat (5) @(posedge clk_i);
    frame({2'h0, 22'h000000});
    check(rx, 24'h060a5c);
    frame({2'h1, 22'h200000});
    frame({2'h0, 22'h000000});
    check(rx, 24'h000000);
    $display("fault flags done");
    // Lockout on: outputs stay off until cleared
    frame({2'h2, 22'h000010});
    supply(1'b1);
    check({22'h0, oen, rel}, 24'h000000);
    supply(1'b0);
    check({23'h0, oen}, 24'h000000);
    frame({2'h1, 22'h200000});
    check({22'h0, oen, rel}, 24'h000003);
    // Lockout off: automatic recovery
    frame({2'h2, 22'h000000});
    supply(1'b1);
    check({23'h0, oen}, 24'h000000);
    supply(1'b0);
    check({22'h0, oen, rel}, 24'h000003);
    frame({2'h2, 22'h080000});
    supply(1'b1);
    check({23'h0, rel}, 24'h000001);
    supply(1'b0);
    $display("supply fault done");
    // Static wake filter, 64 us
    frame({2'h2, 22'h000000});
    @(posedge clk_i);
    wake <= 4'h9;
    repeat (3400) @(posedge clk_i);
    frame({2'h0, 22'h000000});
    check(rx, 24'h012000);
    wake <= 4'h0;
    repeat (3400) @(posedge clk_i);
    frame({2'h0, 22'h000000});
    check(rx, 24'h000000);
    // Cyclic filter on input 0, timer2, 80 us delay then 16 us
    frame({2'h2, 22'h000200});
    @(posedge clk_i);
    tmr2 <= 1'b1;
    wake <= 4'h1;
    repeat (5000) @(posedge clk_i);
    frame({2'h0, 22'h000000});
    check(rx, 24'h002000);
    tmr2 <= 1'b0;
    wake <= 4'h0;
    $display("wake filter done");
    // Mid-run reset
    reset_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check({13'h0, outs}, 24'h000001);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    frame({2'h0, 22'h000000});
    check(rx, 24'h080000);
    frame({2'h2, 22'h000000});
    check(rx, 24'h000000);
    $display("reset done");
    results;
  end
endmodule
